// ===== core/jcr_readback_core.sv
// How it works
// - First returned frame is stale buffer content
// - Decode 000101 as packet input register
// - Decode 001101 as shutdown instruction
// - Done output low while shutdown runs
// - Frame data appears on TDO in Shift-DR
// - Decode 000100 as frame output register
`timescale 1ns/1ps
`default_nettype none
module jcr_readback_core #(
  parameter int FRAME_WORDS = 8,   // Words per configuration frame
  parameter int MEM_AW      = 16   // Configuration memory word address width
) (
  input  wire logic              clk_sys,    // System clock
  input  wire logic              rst_n,      // Async reset, active low
  input  wire logic              tck,        // Test clock from host
  input  wire logic              tms,        // Test mode select
  input  wire logic              tdi,        // Test data in
  output logic                   tdo,        // Test data out
  output logic                   tdoEn,      // TDO driven while high
  output logic                   configDone, // Configuration complete
  output logic [MEM_AW-1:0]      memAddr,    // Frame memory word address
  input  wire logic [15:0]       memData     // Word at memAddr
);
  localparam int IDX_W = (FRAME_WORDS > 1) ? $clog2(FRAME_WORDS) : 1;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(FRAME_WORDS - 1);

  // ---------------- Test clock domain ----------------
  jcr_pkg::jcr_tap_t tapState_q, tapState_d; // TAP controller
  logic [5:0]   irShift_q;   // IR shift stage
  logic [5:0]   instr_q;     // Active instruction
  logic [15:0]  inShift_q;   // Packet input shifter
  logic [15:0]  inWord_q;    // Last complete input word
  logic         inTog_q;     // Flips per input word
  logic [15:0]  outShift_q;  // Frame output shifter
  logic         popTog_q;    // Flips per output word taken
  logic [3:0]   bitCnt_q;    // Bit within a word
  logic         bypass_q;    // One-bit bypass register
  logic         shutBusy_q;  // Shutdown sequence running
  logic [4:0]   shutCnt_q;   // Idle cycles seen in shutdown
  logic         tdo_q;       // TDO, changes on falling TCK
  logic         tdoEn_q;     // TDO enable
  logic [15:0]  outWord_q;   // Next output word, system side

  // TAP next state from TMS
  always_comb begin
    case (tapState_q)
      jcr_pkg::TAP_RESET:  tapState_d = tms ? jcr_pkg::TAP_RESET
                                            : jcr_pkg::TAP_IDLE;
      jcr_pkg::TAP_IDLE:   tapState_d = tms ? jcr_pkg::TAP_SEL_DR
                                            : jcr_pkg::TAP_IDLE;
      jcr_pkg::TAP_SEL_DR: tapState_d = tms ? jcr_pkg::TAP_SEL_IR
                                            : jcr_pkg::TAP_CAP_DR;
      jcr_pkg::TAP_CAP_DR: tapState_d = tms ? jcr_pkg::TAP_EX1_DR
                                            : jcr_pkg::TAP_SH_DR;
      jcr_pkg::TAP_SH_DR:  tapState_d = tms ? jcr_pkg::TAP_EX1_DR
                                            : jcr_pkg::TAP_SH_DR;
      jcr_pkg::TAP_EX1_DR: tapState_d = tms ? jcr_pkg::TAP_UPD_DR
                                            : jcr_pkg::TAP_PA_DR;
      jcr_pkg::TAP_PA_DR:  tapState_d = tms ? jcr_pkg::TAP_EX2_DR
                                            : jcr_pkg::TAP_PA_DR;
      jcr_pkg::TAP_EX2_DR: tapState_d = tms ? jcr_pkg::TAP_UPD_DR
                                            : jcr_pkg::TAP_SH_DR;
      jcr_pkg::TAP_UPD_DR: tapState_d = tms ? jcr_pkg::TAP_SEL_DR
                                            : jcr_pkg::TAP_IDLE;
      jcr_pkg::TAP_SEL_IR: tapState_d = tms ? jcr_pkg::TAP_RESET
                                            : jcr_pkg::TAP_CAP_IR;
      jcr_pkg::TAP_CAP_IR: tapState_d = tms ? jcr_pkg::TAP_EX1_IR
                                            : jcr_pkg::TAP_SH_IR;
      jcr_pkg::TAP_SH_IR:  tapState_d = tms ? jcr_pkg::TAP_EX1_IR
                                            : jcr_pkg::TAP_SH_IR;
      jcr_pkg::TAP_EX1_IR: tapState_d = tms ? jcr_pkg::TAP_UPD_IR
                                            : jcr_pkg::TAP_PA_IR;
      jcr_pkg::TAP_PA_IR:  tapState_d = tms ? jcr_pkg::TAP_EX2_IR
                                            : jcr_pkg::TAP_PA_IR;
      jcr_pkg::TAP_EX2_IR: tapState_d = tms ? jcr_pkg::TAP_UPD_IR
                                            : jcr_pkg::TAP_SH_IR;
      jcr_pkg::TAP_UPD_IR: tapState_d = tms ? jcr_pkg::TAP_SEL_DR
                                            : jcr_pkg::TAP_IDLE;
      default:             tapState_d = jcr_pkg::TAP_RESET;
    endcase
  end

  // TAP state; five TMS highs reach reset from anywhere
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) tapState_q <= jcr_pkg::TAP_RESET;
    else        tapState_q <= tapState_d;
  end

  // Instruction register, LSB arrives first at the top end
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      irShift_q <= jcr_pkg::IR_CAPTURE;
      instr_q   <= jcr_pkg::INSTR_BYPASS;
    end else begin
      case (tapState_q)
        jcr_pkg::TAP_RESET:  instr_q   <= jcr_pkg::INSTR_BYPASS;
        jcr_pkg::TAP_CAP_IR: irShift_q <= jcr_pkg::IR_CAPTURE;
        jcr_pkg::TAP_SH_IR:  irShift_q <= {tdi, irShift_q[5:1]};
        jcr_pkg::TAP_UPD_IR: instr_q   <= irShift_q;
        default: ;
      endcase
    end
  end

  // Data registers: packet input, frame output, bypass
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      inShift_q  <= '0;
      inWord_q   <= '0;
      inTog_q    <= 1'b0;
      outShift_q <= '0;
      popTog_q   <= 1'b0;
      bitCnt_q   <= '0;
      bypass_q   <= 1'b0;
    end else if (tapState_q == jcr_pkg::TAP_CAP_DR) begin
      bitCnt_q <= '0;
      bypass_q <= 1'b0;
      // Take the prepared word and ask for the next one
      if (instr_q == jcr_pkg::INSTR_CFG_OUT) begin
        outShift_q <= outWord_q;
        popTog_q   <= ~popTog_q;
      end
    end else if (tapState_q == jcr_pkg::TAP_SH_DR) begin
      bitCnt_q <= bitCnt_q + 4'h1;
      bypass_q <= tdi;
      if (instr_q == jcr_pkg::INSTR_CFG_IN) begin
        // MSB first; the word is complete on its sixteenth bit
        inShift_q <= {inShift_q[14:0], tdi};
        if (bitCnt_q == jcr_pkg::BIT_LAST) begin
          inWord_q <= {inShift_q[14:0], tdi};
          inTog_q  <= ~inTog_q;
        end
      end else if (instr_q == jcr_pkg::INSTR_CFG_OUT) begin
        // Word boundary reloads; sys side had 16 TCK to refill
        if (bitCnt_q == jcr_pkg::BIT_LAST) begin
          outShift_q <= outWord_q;
          popTog_q   <= ~popTog_q;
        end else begin
          outShift_q <= {outShift_q[14:0], 1'b0};
        end
      end
    end
  end

  // Shutdown timer counts idle cycles after the instruction loads
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      shutBusy_q <= 1'b0;
      shutCnt_q  <= '0;
    end else if (tapState_q == jcr_pkg::TAP_UPD_IR &&
                 irShift_q == jcr_pkg::INSTR_SHUTDOWN) begin
      shutBusy_q <= 1'b1;
      shutCnt_q  <= '0;
    end else if (shutBusy_q && tapState_q == jcr_pkg::TAP_IDLE) begin
      shutCnt_q <= shutCnt_q + 5'd1;
      if (shutCnt_q == jcr_pkg::SHUTDOWN_TCK - 5'd1)
        shutBusy_q <= 1'b0;
    end
  end

  // TDO changes on the falling edge so the host samples it stable
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo_q   <= 1'b0;
      tdoEn_q <= 1'b0;
    end else begin
      tdoEn_q <= (tapState_q == jcr_pkg::TAP_SH_DR) ||
                 (tapState_q == jcr_pkg::TAP_SH_IR);
      if (tapState_q == jcr_pkg::TAP_SH_IR)
        tdo_q <= irShift_q[0];
      else if (instr_q == jcr_pkg::INSTR_CFG_OUT)
        tdo_q <= outShift_q[15];
      else if (instr_q == jcr_pkg::INSTR_CFG_IN)
        tdo_q <= inShift_q[15];
      else
        tdo_q <= bypass_q;
    end
  end

  // ---------------- System clock domain ----------------
  logic [2:0]  inSync_q;    // Input word toggle synchroniser
  logic [2:0]  popSync_q;   // Pop toggle synchroniser
  logic [1:0]  shutSync_q;  // Shutdown level synchroniser
  logic        inValid;     // New input word this cycle
  logic        popReq;      // TCK side took the output word
  jcr_pkg::jcr_parse_t psState_q; // Packet parser
  jcr_pkg::jcr_hdr_t   hdr;       // Current word as header
  logic [5:0]  target_q;    // Register being written
  logic [4:0]  remain_q;    // Payload words left
  logic [15:0] cmd_q;       // Last command value
  logic [31:0] far_q;       // Start frame address
  logic [15:0] len_q;       // Readback length in words
  logic        rcfgArmed_q; // Readback command seen
  logic        readStart_q; // One-cycle readback start
  logic [15:0] rbRemain_q;  // Words still to fetch
  logic [IDX_W-1:0] bufIdx_q;   // Frame buffer slot
  logic [15:0] frameBuf [FRAME_WORDS]; // One-frame pipeline buffer
  logic [15:0] bufHead;     // Slot about to be emitted
  logic        done_q;      // Configuration complete
  logic [MEM_AW-1:0] memAddr_q; // Memory word address

  // Crossings: toggles and a level, two flops before any use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inSync_q   <= '0;
      popSync_q  <= '0;
      shutSync_q <= '0;
    end else begin
      inSync_q   <= {inSync_q[1:0], inTog_q};
      popSync_q  <= {popSync_q[1:0], popTog_q};
      shutSync_q <= {shutSync_q[0], shutBusy_q};
    end
  end

  // Input word is stable for 16 TCK after its toggle
  assign inValid = inSync_q[2] ^ inSync_q[1];
  assign popReq  = popSync_q[2] ^ popSync_q[1];
  assign hdr     = inWord_q;
  assign bufHead = frameBuf[bufIdx_q];

  // Packet parser: sync, headers and payload words
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      psState_q   <= jcr_pkg::PS_SYNC_HI;
      target_q    <= '0;
      remain_q    <= '0;
      cmd_q       <= '0;
      far_q       <= '0;
      len_q       <= '0;
      rcfgArmed_q <= 1'b0;
      readStart_q <= 1'b0;
    end else begin
      readStart_q <= 1'b0;
      if (inValid) begin
        case (psState_q)
          // Dummy words are skipped while hunting for sync
          jcr_pkg::PS_SYNC_HI:
            if (inWord_q == jcr_pkg::SYNC_HI)
              psState_q <= jcr_pkg::PS_SYNC_LO;
          jcr_pkg::PS_SYNC_LO:
            psState_q <= (inWord_q == jcr_pkg::SYNC_LO)
                         ? jcr_pkg::PS_HEADER
                         : jcr_pkg::PS_SYNC_HI;
          jcr_pkg::PS_HEADER: begin
            // No-op headers carry no payload and just flush
            if (hdr.op == jcr_pkg::OP_WRITE &&
                hdr.kind == jcr_pkg::HDR_TYPE1 && hdr.count != '0) begin
              target_q  <= hdr.addr;
              remain_q  <= hdr.count;
              psState_q <= jcr_pkg::PS_PAYLOAD;
            end else if (hdr.op == jcr_pkg::OP_READ &&
                         hdr.addr == jcr_pkg::ADDR_FRAME_OUT &&
                         rcfgArmed_q) begin
              readStart_q <= 1'b1;
              rcfgArmed_q <= 1'b0;
            end
          end
          jcr_pkg::PS_PAYLOAD: begin
            case (target_q)
              jcr_pkg::ADDR_CMD: begin
                cmd_q <= inWord_q;
                if (inWord_q == jcr_pkg::CMD_READBACK)
                  rcfgArmed_q <= 1'b1;
              end
              jcr_pkg::ADDR_FAR: far_q <= {far_q[15:0], inWord_q};
              jcr_pkg::ADDR_LEN: len_q <= inWord_q;
              default: ;
            endcase
            remain_q <= remain_q - 5'd1;
            if (remain_q == 5'd1)
              psState_q <= jcr_pkg::PS_HEADER;
          end
          default: psState_q <= jcr_pkg::PS_SYNC_HI;
        endcase
      end
    end
  end

  // Frame buffer: each emitted word is the one stored a frame
  // earlier, so the first frame out is stale by construction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      outWord_q  <= '0;
      rbRemain_q <= '0;
      bufIdx_q   <= '0;
      memAddr_q  <= '0;
      for (int i = 0; i < FRAME_WORDS; i++)
        frameBuf[i] <= '0;
    end else if (readStart_q) begin
      rbRemain_q <= len_q;
      bufIdx_q   <= '0;
      memAddr_q  <= far_q[MEM_AW-1:0];
    end else if (popReq || (rbRemain_q == len_q && len_q != '0 &&
                            bufIdx_q == '0 && memAddr_q ==
                            far_q[MEM_AW-1:0])) begin
      if (rbRemain_q != '0) begin
        outWord_q          <= bufHead;
        frameBuf[bufIdx_q] <= memData;
        memAddr_q          <= memAddr_q + MEM_AW'(1);
        rbRemain_q         <= rbRemain_q - 16'h1;
        bufIdx_q <= (bufIdx_q == IDX_LAST) ? '0 : bufIdx_q + IDX_W'(1);
      end else begin
        outWord_q <= '0;
      end
    end
  end

  // Done falls when shutdown starts and stays low until reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)             done_q <= 1'b1;
    else if (shutSync_q[1]) done_q <= 1'b0;
  end

  assign tdo        = tdo_q;
  assign tdoEn      = tdoEn_q;
  assign configDone = done_q;
  assign memAddr    = memAddr_q;

  // ---------------- Checks ----------------
  cfg_in_decode_a: assert property (@(posedge tck) disable iff (!rst_n)
    tapState_q == jcr_pkg::TAP_UPD_IR && irShift_q == jcr_pkg::INSTR_CFG_IN
    |=> instr_q == jcr_pkg::INSTR_CFG_IN)
    else $error("packet input instruction not decoded");
  cfg_out_decode_a: assert property (@(posedge tck) disable iff (!rst_n)
    tapState_q == jcr_pkg::TAP_UPD_IR && irShift_q == jcr_pkg::INSTR_CFG_OUT
    |=> instr_q == jcr_pkg::INSTR_CFG_OUT)
    else $error("frame output instruction not decoded");
  shutdown_start_a: assert property (@(posedge tck) disable iff (!rst_n)
    tapState_q == jcr_pkg::TAP_UPD_IR &&
    irShift_q == jcr_pkg::INSTR_SHUTDOWN |=> shutBusy_q && shutCnt_q == '0)
    else $error("shutdown did not start");
  shutdown_end_a: assert property (@(posedge tck) disable iff (!rst_n)
    shutBusy_q && tapState_q == jcr_pkg::TAP_IDLE &&
    shutCnt_q == jcr_pkg::SHUTDOWN_TCK - 5'h01
    |=> !shutBusy_q)
    else $error("shutdown did not end after 24 idle cycles");
  ir_capture_a: assert property (@(posedge tck) disable iff (!rst_n)
    tapState_q == jcr_pkg::TAP_SH_IR |=> irShift_q[5] == $past(tdi))
    else $error("instruction bit not taken from TDI");
  tdo_frame_a: assert property (@(posedge tck) disable iff (!rst_n)
    tapState_q == jcr_pkg::TAP_SH_DR && $past(tapState_q) ==
    jcr_pkg::TAP_SH_DR && instr_q == jcr_pkg::INSTR_CFG_OUT
    |-> tdoEn_q && tdo_q == outShift_q[15])
    else $error("TDO does not show frame output bit");
  done_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    shutSync_q[1] |=> !configDone ##1 !configDone)
    else $error("done high during shutdown");
  stale_frame_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    popReq && !readStart_q && rbRemain_q != '0
    |=> outWord_q == $past(bufHead) && frameBuf[$past(bufIdx_q)] ==
        $past(memData))
    else $error("frame buffer order broken");
  sync_accept_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    inValid && psState_q == jcr_pkg::PS_SYNC_LO &&
    inWord_q == jcr_pkg::SYNC_LO |=> psState_q == jcr_pkg::PS_HEADER)
    else $error("sync pair not accepted");
endmodule
`default_nettype wire

// ===== pkg/jcr_pkg.sv
`default_nettype none
package jcr_pkg;
  // TAP controller states of the boundary-scan port
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } jcr_tap_t;

  // Packet parser states
  typedef enum logic [1:0] {
    PS_SYNC_HI, PS_SYNC_LO, PS_HEADER, PS_PAYLOAD
  } jcr_parse_t;

  // Instruction register
  localparam int          IR_W            = 6;
  localparam logic [5:0]  INSTR_CFG_IN    = 6'h05;  // Packets in
  localparam logic [5:0]  INSTR_CFG_OUT   = 6'h04;  // Frames out
  localparam logic [5:0]  INSTR_SHUTDOWN  = 6'h0D;  // Shutdown sequence
  localparam logic [5:0]  INSTR_BYPASS    = 6'h3F;  // Default after reset
  localparam logic [5:0]  IR_CAPTURE      = 6'h01;  // Fixed capture value

  // Packet words
  localparam int          WORD_W          = 16;
  localparam logic [3:0]  BIT_LAST        = 4'hF;   // Last bit of a word
  localparam logic [15:0] SYNC_HI         = 16'hAA99;
  localparam logic [15:0] SYNC_LO         = 16'h5566;
  localparam logic [2:0]  HDR_TYPE1       = 3'h1;
  localparam logic [1:0]  OP_READ         = 2'h1;
  localparam logic [1:0]  OP_WRITE        = 2'h2;
  localparam logic [5:0]  ADDR_FAR        = 6'h01;  // frame_address_register
  localparam logic [5:0]  ADDR_FRAME_OUT  = 6'h04;  // frame_output_register
  localparam logic [5:0]  ADDR_CMD        = 6'h05;  // Command register
  localparam logic [5:0]  ADDR_LEN        = 6'h0D;  // Readback length
  localparam logic [15:0] CMD_READBACK    = 16'h0004; // readback_config_command

  // Shutdown runs for this many idle TCK cycles
  localparam logic [4:0]  SHUTDOWN_TCK    = 5'd24;

  // Packet header fields
  typedef struct packed {
    logic [2:0] kind;
    logic [1:0] op;
    logic [5:0] addr;
    logic [4:0] count;
  } jcr_hdr_t;
endpackage
`default_nettype wire

// ===== bench/jcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module jcr_host_model (
  output logic      tck,   // Test clock, stands low between steps
  output logic      tms,   // Mode select to device
  output logic      tdi,   // Data to device
  input  wire logic tdo,   // Data from device
  input  wire logic tdoEn  // Device drives tdo
);
  logic enAll;             // Every shifted bit had tdo driven
  logic enNow;             // tdoEn as seen at the end of the low phase, just before rise

  // Idle levels before the first step
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    enAll = 1'b1;
  end

  // One 30 ns period; tdo settled since the falling edge, read before rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #15.0;
    // A released line reads as its pull-up
    q = tdoEn ? tdo : 1'b1;
    enNow = tdoEn;
    tck = 1'b1;
    #15.0;
    tck = 1'b0;
  endtask

  // State move; tdi toggles so a device that samples it is caught
  task automatic walk(input logic m);
    logic q;
    step(m, ~tdi, q);
  endtask

  task automatic tap_reset();
    repeat (5) walk(1'b1);
    walk(1'b0);
  endtask

  task automatic idle(input int n);
    repeat (n) walk(1'b0);
  endtask

  // From Idle or an Update state; ends in Update-IR
  task automatic load_ir(input logic [5:0] code, output logic [5:0] cap);
    walk(1'b1);
    walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    for (int i = 0; i < 6; i++) begin
      step(i == 5, code[i], cap[i]);
      enAll &= enNow;
    end
    walk(1'b1);
  endtask

  // Words MSB first, last bit leaves Shift-DR; ends in Update-DR
  task automatic shift_dr(input logic [15:0] wIn[$],
                          output logic [15:0] wOut[$]);
    logic [15:0] w;
    walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    wOut = {};
    foreach (wIn[k]) begin
      for (int b = 15; b >= 0; b--) begin
        step((k == wIn.size() - 1) && (b == 0), wIn[k][b], w[b]);
        enAll &= enNow;
      end
      wOut.push_back(w);
    end
    walk(1'b1);
  endtask
endmodule
`default_nettype wire

// ===== bench/jcr_readback_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module jcr_readback_core_tb;
  localparam int FW = 8;         // Frame depth handed to the design
  logic        clk_sys;          // System clock
  logic        rst_n;            // Reset, active low
  logic        tck;              // Test clock from host model
  logic        tms;              // Mode select
  logic        tdi;              // Data in
  logic        tdo;              // Data out
  logic        tdoEn;            // Data out enable
  logic        configDone;       // Configuration complete
  logic [15:0] memAddr;          // Frame memory address
  logic [15:0] memData;          // Frame memory word
  logic [15:0] wIn[$];           // Words to shift in
  logic [15:0] wOut[$];          // Words shifted out
  logic [5:0]  cap;              // Captured instruction bits
  int          err_total;        // Mismatches
  int          n_compared;       // Comparisons
  int          cycles;           // Watchdog count

  jcr_readback_core #(.FRAME_WORDS(FW), .MEM_AW(16)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .configDone(configDone),
    .memAddr(memAddr), .memData(memData));
  jcr_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoEn(tdoEn));

  // Zero-latency memory; contents differ per address so order shows
  assign memData = memAddr ^ 16'h5A3C;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Watchdog: whole flow needs about 2200 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
    end
  end

  task automatic check16(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp, input string msg);
    check16({15'h0, got}, {15'h0, exp}, msg);
  endtask

  task automatic finish_test();
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Values while reset is held
  task automatic t_reset_values();
    check1(configDone, 1'b1, "done in reset");
    check1(tdoEn, 1'b0, "tdo enable in reset");
    check16(memAddr, 16'h0000, "address in reset");
  endtask

  // First pass: 7 words, then shutdown with done falling
  task automatic t_shutdown();
    host.tap_reset();
    host.load_ir(jcr_pkg::INSTR_CFG_IN, cap);
    check16({10'h000, cap}, {10'h000, jcr_pkg::IR_CAPTURE}, "ir cap");
    wIn = {16'hFFFF, 16'hAA99, 16'h5566, 16'h30A1, 16'h0007,
           16'h2000, 16'h2000};
    host.shift_dr(wIn, wOut);
    check1(host.enAll, 1'b1, "tdo enable while shifting");
    check1(configDone, 1'b1, "done before shutdown");
    host.load_ir(jcr_pkg::INSTR_SHUTDOWN, cap);
    host.idle(5);
    check1(configDone, 1'b0, "done during shutdown");
    host.idle(20);
    check1(configDone, 1'b0, "done after shutdown");
  endtask

  // Second pass, then two frames out: a stale one and memory from 0x10
  task automatic t_readback();
    logic [15:0] exp;
    host.load_ir(jcr_pkg::INSTR_CFG_IN, cap);
    wIn = {16'hFFFF, 16'hAA99, 16'h5566, 16'h30A1, 16'h0008,
           16'h31A1, 16'h0010, 16'h3022, 16'h0000, 16'h0010,
           16'h30A1, 16'h0004, 16'h4880, 16'h0000, 16'h2000, 16'h2000};
    host.shift_dr(wIn, wOut);
    host.load_ir(jcr_pkg::INSTR_CFG_OUT, cap);
    wIn = {};
    repeat (2 * FW) wIn.push_back(16'h0000);
    host.shift_dr(wIn, wOut);
    for (int i = 0; i < 2 * FW; i++) begin
      exp = (i < FW) ? 16'h0000 : ((16'h0010 + 16'(i - FW)) ^ 16'h5A3C);
      check16(wOut[i], exp, "readback word");
    end
    check1(host.enAll, 1'b1, "tdo enable while reading");
    // Start address plus the programmed length of fetched words
    check16(memAddr, 16'h0020, "address after readback");
    host.tap_reset();
  endtask

  // Second reset mid-run restores done and releases tdo
  task automatic t_rereset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    check1(configDone, 1'b1, "done after reset");
    check1(tdoEn, 1'b0, "tdo enable after reset");
    @(posedge clk_sys);
    rst_n <= 1'b1;
    // Port must answer again straight after release
    host.tap_reset();
    host.load_ir(jcr_pkg::INSTR_CFG_IN, cap);
    check16({10'h000, cap}, {10'h000, jcr_pkg::IR_CAPTURE},
            "ir cap again");
    check1(configDone, 1'b1, "done after release");
  endtask

  initial begin
    rst_n = 1'b0;
    err_total = 0;
    n_compared = 0;
    cycles = 0;
    #3.7;
    host.idle(2);
    repeat (20) @(posedge clk_sys);
    t_reset_values();
    rst_n <= 1'b1;
    #3.7;
    t_shutdown();
    t_readback();
    t_rereset();
    finish_test();
  end
endmodule
`default_nettype wire
